/* File: hw/rail_seq_defines.vh */
`ifndef RAIL_SEQ_DEFINES_VH
`define RAIL_SEQ_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define SEQ_CONFIG_OFFSET            5'h01
`define SEQ_STATUS_OFFSET            5'h02
`define BOOST_RAIL_CONTROL_OFFSET    5'h08
`define STEP_DOWN_A_DELAY_OFFSET     5'h09
`define STEP_DOWN_B_DELAY_OFFSET     5'h0a
`define BOOST_DELAY_OFFSET           5'h0b
`define GENERAL_OUTPUT_A_DELAY_OFFSET 5'h0c

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BOOST_RAIL_CONTROL_RESET     8'h08
`define SEQUENCE_DELAY_RESET         8'h00
`define SEQ_CONFIG_RESET             8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BOOST_LEVEL_MSB              7
`define BOOST_LEVEL_LSB              6
`define BOOST_GATE_MSB               2
`define BOOST_GATE_LSB               1
`define BOOST_ON_BIT                 0
`define FALL_WAIT_MSB                7
`define FALL_WAIT_LSB                4
`define RISE_WAIT_MSB                3
`define RISE_WAIT_LSB                0
`define DELAY_SCALE_BIT              0

// ----------------------------------------------------------------------
// Pin gating codes
// ----------------------------------------------------------------------
`define GATE_NONE                    2'h0
`define GATE_PIN_ONE                 2'h1
`define GATE_PIN_TWO                 2'h2
`define GATE_PIN_THREE               2'h3

// ----------------------------------------------------------------------
// Boost output level in millivolts per code
// ----------------------------------------------------------------------
`define BOOST_LEVEL_0_MV             13'h1324
`define BOOST_LEVEL_1_MV             13'h1388
`define BOOST_LEVEL_2_MV             13'h13ec
`define BOOST_LEVEL_3_MV             13'h1450

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ                 125
`define DELAY_STEP_TIME_US           500
`define DELAY_STEP_CYCLES            (`DELAY_STEP_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: hw/rail_enable_delay_sequencer.v */
// Decided for this implementation: the plain strobed port.

`include "rail_seq_defines.vh"

module rail_enable_delay_sequencer #(
  parameter STEP_CYCLES = `DELAY_STEP_CYCLES,
  parameter PW          = 17
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire [1:0]  otp_boost_level,
  input  wire        ctl_pin_one,
  input  wire        ctl_pin_two,
  input  wire        ctl_pin_three,
  input  wire        step_down_a_ctl,
  input  wire        step_down_b_ctl,
  input  wire        general_output_a_ctl,
  output wire        step_down_a_on,
  output wire        step_down_b_on,
  output wire        boost_on,
  output wire        general_output_a_on,
  output wire        boost_ctl,
  output wire [1:0]  boost_level_sel,
  output reg  [12:0] boost_level_mv
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam NCH = 4;

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  reg  [7:0]     boost_rail_control;
  reg  [7:0]     seq_config;
  reg  [7:0]     seq_delay [0:NCH-1];
  reg            level_loaded;
  reg  [2:0]     pin_meta;
  reg  [2:0]     pin_sync;
  wire [NCH-1:0] ctl_vec;
  wire [NCH-1:0] rail_out_vec;
  wire [NCH-1:0] pending_vec;
  reg            gate_pin;
  wire           delay_scale;
  integer        i;

  assign delay_scale     = seq_config[`DELAY_SCALE_BIT];
  assign boost_level_sel = boost_rail_control[`BOOST_LEVEL_MSB:`BOOST_LEVEL_LSB];

  // ----------------------------------------------------------------------
  // Enable pin synchronisers
  // ----------------------------------------------------------------------

  // Two flip-flops per pin; only the second stage is read by logic.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {ctl_pin_three, ctl_pin_two, ctl_pin_one};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Boost control gating
  // ----------------------------------------------------------------------

  // Select the pin that gates the boost on bit, or none.
  always @* begin
    case (boost_rail_control[`BOOST_GATE_MSB:`BOOST_GATE_LSB])
      `GATE_NONE:      gate_pin = 1'b1;
      `GATE_PIN_ONE:   gate_pin = pin_sync[0];
      `GATE_PIN_TWO:   gate_pin = pin_sync[1];
      `GATE_PIN_THREE: gate_pin = pin_sync[2];
      default:         gate_pin = 1'b0;
    endcase
  end

  // The on bit alone decides when ungated, and is ANDed with a pin otherwise.
  assign boost_ctl = boost_rail_control[`BOOST_ON_BIT] & gate_pin;

  // Control signals of the four sequenced outputs.
  assign ctl_vec = {general_output_a_ctl, boost_ctl, step_down_b_ctl, step_down_a_ctl};

  // ----------------------------------------------------------------------
  // Boost level decode
  // ----------------------------------------------------------------------

  // Convert the level code into the regulated target in millivolts.
  always @* begin
    case (boost_level_sel)
      2'h0:    boost_level_mv = `BOOST_LEVEL_0_MV;
      2'h1:    boost_level_mv = `BOOST_LEVEL_1_MV;
      2'h2:    boost_level_mv = `BOOST_LEVEL_2_MV;
      2'h3:    boost_level_mv = `BOOST_LEVEL_3_MV;
      default: boost_level_mv = `BOOST_LEVEL_0_MV;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // The level field is taken from the programmed input at the first edge
  // after reset release; a write in that same cycle takes priority.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      boost_rail_control <= `BOOST_RAIL_CONTROL_RESET;
      seq_config         <= `SEQ_CONFIG_RESET;
      level_loaded       <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        seq_delay[i] <= `SEQUENCE_DELAY_RESET;
      end
    end else begin
      if (!level_loaded) begin
        level_loaded <= 1'b1;
        boost_rail_control[`BOOST_LEVEL_MSB:`BOOST_LEVEL_LSB] <= otp_boost_level;
      end
      if (reg_write) begin
        case (reg_addr)
          `SEQ_CONFIG_OFFSET:             seq_config <= {7'h00, reg_wdata[0]};
          `BOOST_RAIL_CONTROL_OFFSET:     boost_rail_control <= reg_wdata;
          `STEP_DOWN_A_DELAY_OFFSET:      seq_delay[0] <= reg_wdata;
          `STEP_DOWN_B_DELAY_OFFSET:      seq_delay[1] <= reg_wdata;
          `BOOST_DELAY_OFFSET:            seq_delay[2] <= reg_wdata;
          `GENERAL_OUTPUT_A_DELAY_OFFSET: seq_delay[3] <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------

  // Read data appear one cycle after the strobe; unmapped addresses read zero.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `SEQ_CONFIG_OFFSET:             reg_rdata <= seq_config;
        `SEQ_STATUS_OFFSET:             reg_rdata <= {pending_vec, rail_out_vec};
        `BOOST_RAIL_CONTROL_OFFSET:     reg_rdata <= boost_rail_control;
        `STEP_DOWN_A_DELAY_OFFSET:      reg_rdata <= seq_delay[0];
        `STEP_DOWN_B_DELAY_OFFSET:      reg_rdata <= seq_delay[1];
        `BOOST_DELAY_OFFSET:            reg_rdata <= seq_delay[2];
        `GENERAL_OUTPUT_A_DELAY_OFFSET: reg_rdata <= seq_delay[3];
        default:                        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Delay sequencers, one per output
  // ----------------------------------------------------------------------

  // Step-down A rail, timed from its own control input.
  rail_delay_channel #(
    .STEP_CYCLES (STEP_CYCLES),
    .PW          (PW)
  ) u_step_down_a_seq (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ctl         (ctl_vec[0]),
    .rise_code   (seq_delay[0][`RISE_WAIT_MSB:`RISE_WAIT_LSB]),
    .fall_code   (seq_delay[0][`FALL_WAIT_MSB:`FALL_WAIT_LSB]),
    .delay_scale (delay_scale),
    .rail_out    (rail_out_vec[0]),
    .pending     (pending_vec[0])
  );

  // Step-down B rail, timed from its own control input.
  rail_delay_channel #(
    .STEP_CYCLES (STEP_CYCLES),
    .PW          (PW)
  ) u_step_down_b_seq (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ctl         (ctl_vec[1]),
    .rise_code   (seq_delay[1][`RISE_WAIT_MSB:`RISE_WAIT_LSB]),
    .fall_code   (seq_delay[1][`FALL_WAIT_MSB:`FALL_WAIT_LSB]),
    .delay_scale (delay_scale),
    .rail_out    (rail_out_vec[1]),
    .pending     (pending_vec[1])
  );

  // Boost rail, timed from the gated boost control.
  rail_delay_channel #(
    .STEP_CYCLES (STEP_CYCLES),
    .PW          (PW)
  ) u_boost_seq (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ctl         (ctl_vec[2]),
    .rise_code   (seq_delay[2][`RISE_WAIT_MSB:`RISE_WAIT_LSB]),
    .fall_code   (seq_delay[2][`FALL_WAIT_MSB:`FALL_WAIT_LSB]),
    .delay_scale (delay_scale),
    .rail_out    (rail_out_vec[2]),
    .pending     (pending_vec[2])
  );

  // General output A, timed from its own control input.
  rail_delay_channel #(
    .STEP_CYCLES (STEP_CYCLES),
    .PW          (PW)
  ) u_general_output_a_seq (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ctl         (ctl_vec[3]),
    .rise_code   (seq_delay[3][`RISE_WAIT_MSB:`RISE_WAIT_LSB]),
    .fall_code   (seq_delay[3][`FALL_WAIT_MSB:`FALL_WAIT_LSB]),
    .delay_scale (delay_scale),
    .rail_out    (rail_out_vec[3]),
    .pending     (pending_vec[3])
  );

  // Sequenced outputs, each straight from its flip-flop.
  assign step_down_a_on      = rail_out_vec[0];
  assign step_down_b_on      = rail_out_vec[1];
  assign boost_on            = rail_out_vec[2];
  assign general_output_a_on = rail_out_vec[3];

endmodule // rail_enable_delay_sequencer

// ----------------------------------------------------------------------
// One sequenced output: times each control edge, then passes the level on
// ----------------------------------------------------------------------

// The control level is compared with the last level seen on every edge.
// A change starts a new delay, so a glitch that returns within the delay
// re-times and ends with no output change at all.
// The prescaler divides the clock into half-millisecond steps and runs
// only while a change is pending, which keeps the output quiet between
// transitions and saves toggling in the long idle periods.
// The code and the scale are captured at the control edge, so a register
// write during a running delay only affects the next transition.
// A code of zero passes the new level on at the edge itself.
// The step count is five bits wide, enough for fifteen 1 ms steps.
// Users must keep PW wide enough to hold STEP_CYCLES minus one.
module rail_delay_channel #(
  parameter STEP_CYCLES = `DELAY_STEP_CYCLES,
  parameter PW          = 17
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       ctl,
  input  wire [3:0] rise_code,
  input  wire [3:0] fall_code,
  input  wire       delay_scale,
  output reg        rail_out,
  output reg        pending
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam integer  STEP_LAST_INT = STEP_CYCLES - 1;
  localparam [PW-1:0] STEP_LAST     = STEP_LAST_INT[PW-1:0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg           last_ctl;
  reg  [4:0]    remain;
  reg  [PW-1:0] presc;
  wire [3:0]    code;
  wire [4:0]    wait_units;
  wire          step_tick;

  // Pick the rising or falling code for the edge now seen.
  assign code = ctl ? rise_code : fall_code;

  // Half-millisecond units: code, or twice the code in 1 ms mode.
  assign wait_units = delay_scale ? {code, 1'b0} : {1'b0, code};

  // One-cycle enable at the end of each half-millisecond step.
  assign step_tick = (presc == STEP_LAST);

  // Time the latest control edge and then pass the level to the output.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_ctl <= 1'b0;
      rail_out <= 1'b0;
      pending  <= 1'b0;
      remain   <= 5'h00;
      presc    <= {PW{1'b0}};
    end else if (ctl != last_ctl) begin
      // A fresh edge restarts timing and drops any pending change.
      last_ctl <= ctl;
      presc    <= {PW{1'b0}};
      remain   <= wait_units;
      if (wait_units == 5'h00) begin
        rail_out <= ctl;
        pending  <= 1'b0;
      end else begin
        pending  <= 1'b1;
      end
    end else if (pending) begin
      // Count whole steps; the last one applies the timed level.
      if (step_tick) begin
        presc  <= {PW{1'b0}};
        remain <= remain - 5'h01;
        if (remain == 5'h01) begin
          rail_out <= last_ctl;
          pending  <= 1'b0;
        end
      end else begin
        presc <= presc + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // rail_delay_channel

/* File: verif/rail_seq_monitor.sv */
module rail_seq_monitor #(
  parameter STEP_CYCLES = 4
) (
  input wire        sys_clk,
  input wire        reset,
  input wire [4:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_write,
  input wire [1:0]  otp_boost_level,
  input wire        ctl_pin_one,
  input wire        ctl_pin_two,
  input wire        ctl_pin_three,
  input wire        step_down_a_ctl,
  input wire        step_down_b_ctl,
  input wire        general_output_a_ctl,
  input wire        step_down_a_on,
  input wire        step_down_b_on,
  input wire        boost_on,
  input wire        general_output_a_on,
  input wire        boost_ctl,
  input wire [1:0]  boost_level_sel,
  input wire [12:0] boost_level_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  sh [16];
  logic [2:0]  pd1, pd2;
  logic [3:0]  last;
  logic [31:0] cnt [4];
  logic [31:0] lim [4];
  wire  [3:0]  ctl = {general_output_a_ctl, boost_ctl, step_down_b_ctl, step_down_a_ctl};
  wire  [3:0]  on  = {general_output_a_on, boost_on, step_down_b_on, step_down_a_on};
  wire  [1:0]  gate = sh[8][2:1];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Shadows the registers and the pin synchroniser, and times each control edge.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) sh[i] <= (i == 8) ? 8'h08 : 8'h00;
      pd1 <= 3'h0;
      pd2 <= 3'h0;
      last <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= 32'h0;
        lim[i] <= 32'h0;
      end
    end else begin
      if (reg_write && reg_addr < 5'h10) sh[reg_addr[3:0]] <= reg_wdata;
      pd1 <= {ctl_pin_three, ctl_pin_two, ctl_pin_one};
      pd2 <= pd1;
      last <= ctl;
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= (ctl[i] != last[i]) ? 32'h1 : cnt[i] + 32'h1;
        if (ctl[i] != last[i]) lim[i] <= (ctl[i] ? sh[9+i][3:0] : sh[9+i][7:4])
                                         * STEP_CYCLES * (sh[1][0] ? 2 : 1) + 1;
      end
    end
  end

  a_level_decode: assert property (
    boost_level_mv == 13'h1324 + 13'h064 * boost_level_sel) else $error("bad level decode");
  a_level_load: assert property (
    $fell(reset) |=> boost_level_sel == $past(otp_boost_level)) else $error("level not loaded");
  a_level_write: assert property (
    reg_write && reg_addr == 5'h08 |=> boost_level_sel == $past(reg_wdata[7:6]))
    else $error("level not written");
  a_gate_none: assert property (
    gate == 2'h0 |-> boost_ctl == sh[8][0]) else $error("ungated boost control wrong");
  a_gate_pin: assert property (
    gate != 2'h0 |-> boost_ctl == (sh[8][0] & pd2[gate - 2'h1])) else $error("pin gating wrong");
  a_on_bit_off: assert property (
    !sh[8][0] |-> !boost_ctl) else $error("boost on while bit clear");
  for (genvar c = 0; c < 4; c++) begin : g_chan
    a_wait_length: assert property (
      $changed(on[c]) |-> cnt[c] == lim[c] && on[c] == last[c]) else $error("output moved early");
    a_wait_settle: assert property (
      cnt[c] == lim[c] |-> on[c] == last[c]) else $error("output missed its change");
  end
  c_boost_up: cover property ($rose(boost_on));
  c_long_step: cover property (sh[1][0] && $rose(step_down_a_on));
  c_pin_three: cover property (gate == 2'h3 && boost_ctl);
endmodule // rail_seq_monitor

bind rail_enable_delay_sequencer rail_seq_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (
  .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .otp_boost_level, .ctl_pin_one,
  .ctl_pin_two, .ctl_pin_three, .step_down_a_ctl, .step_down_b_ctl, .general_output_a_ctl,
  .step_down_a_on, .step_down_b_on, .boost_on, .general_output_a_on, .boost_ctl,
  .boost_level_sel, .boost_level_mv);

/* File: verif/enable_pin_host.sv */
module enable_pin_host (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire [2:0] pin_req,
  output logic      ctl_pin_one,
  output logic      ctl_pin_two,
  output logic      ctl_pin_three
);
  timeunit 1ns;
  timeprecision 1ns;
  // Drives the enable pins one clock after the host asks, as a host output port would.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) {ctl_pin_three, ctl_pin_two, ctl_pin_one} <= 3'h0;
    else {ctl_pin_three, ctl_pin_two, ctl_pin_one} <= pin_req;
  end
endmodule // enable_pin_host

/* File: verif/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 4;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [1:0] otp_boost_level = 2'h2;
  logic [2:0] pin_req = 3'h0;
  logic [3:0] ctl_in = 4'h0;
  logic [3:0] rw [4] = '{4'hf, 4'h0, 4'h1, 4'h5};
  logic [3:0] fw [4] = '{4'h0, 4'hf, 4'h3, 4'h1};
  wire        ctl_pin_one, ctl_pin_two, ctl_pin_three, boost_ctl;
  wire [7:0]  reg_rdata;
  wire [3:0]  on;
  wire [1:0]  boost_level_sel;
  wire [12:0] boost_level_mv;
  int         error_cnt = 0;
  int         compares = 0;
  int         cycles = 0;

  rail_enable_delay_sequencer #(.STEP_CYCLES(SC)) u_rail_enable_delay_sequencer (
    .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .otp_boost_level, .ctl_pin_one, .ctl_pin_two, .ctl_pin_three,
    .step_down_a_ctl(ctl_in[0]), .step_down_b_ctl(ctl_in[1]), .general_output_a_ctl(ctl_in[3]),
    .step_down_a_on(on[0]), .step_down_b_on(on[1]), .boost_on(on[2]),
    .general_output_a_on(on[3]), .boost_ctl, .boost_level_sel, .boost_level_mv);
  enable_pin_host u_enable_pin_host (
    .sys_clk, .reset, .pin_req, .ctl_pin_one, .ctl_pin_two, .ctl_pin_three);

  // Free-running clock and a hang guard.
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk(nm, reg_rdata, e);
  endtask
  task automatic set_ctl(input int ch, input logic lv);
    if (ch == 2) wr(5'h08, {7'h00, lv});
    else begin
      @(posedge sys_clk);
      ctl_in[ch] <= lv;
    end
  endtask
  task automatic go(input int ch, input logic lv, input int n_exp, input string nm);
    int n;
    n = 0;
    while (on[ch] !== lv && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(nm, n, n_exp);
  endtask
  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence: reset values, level decode, gating, delays, abandoned edges.
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(5'h08, 8'h88, "boost_rail_control");
    for (int r = 9; r < 13; r++) rd(5'(r), 8'h00, "delay reset");
    rd(5'h1f, 8'h00, "unmapped");
    for (int k = 0; k < 4; k++) begin
      wr(5'h08, 8'(k << 6));
      #1;
      chk("boost_level_mv", boost_level_mv, 13'h1324 + 13'h064 * k);
    end
    $display("test level done");
    @(posedge sys_clk);
    pin_req <= 3'h5;
    for (int g = 0; g < 4; g++) begin
      wr(5'h08, 8'((g << 1) | 1));
      repeat (4) @(posedge sys_clk);
      #1;
      chk("boost_ctl", boost_ctl, (g == 0) ? 1'b1 : pin_req[g-1]);
    end
    wr(5'h08, 8'h06);
    #1;
    chk("boost_ctl off", boost_ctl, 1'b0);
    wr(5'h08, 8'h00);
    $display("test gating done");
    for (int s = 0; s < 2; s++) begin
      wr(5'h01, 8'(s));
      for (int ch = 0; ch < 4; ch++) begin
        wr(5'(9 + ch), {fw[ch], rw[ch]});
        set_ctl(ch, 1'b1);
        go(ch, 1'b1, 1 + rw[ch] * SC * (s + 1), "rise wait");
        set_ctl(ch, 1'b0);
        go(ch, 1'b0, 1 + fw[ch] * SC * (s + 1), "fall wait");
      end
    end
    rd(5'h01, 8'h01, "config");
    $display("test delays done");
    wr(5'h09, 8'h24);
    set_ctl(0, 1'b1);
    repeat (5) @(posedge sys_clk);
    set_ctl(0, 1'b0);
    repeat (40) @(posedge sys_clk);
    #1;
    chk("abandoned rise", on[0], 1'b0);
    set_ctl(0, 1'b1);
    go(0, 1'b1, 1 + 4 * SC * 2, "retimed rise");
    wr(5'h02, 8'hff);
    rd(5'h02, 8'h01, "status");
    $display("test abort done");
    wrap_up();
  end
endmodule // tb
